//--- inc/timer_ctl_regs.svh
// register offsets, field positions, reset values for the timer control block
// assumes an 8-bit register port with a 4-bit word address
`ifndef TIMER_CTL_REGS_SVH
`define TIMER_CTL_REGS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_CONTROL    4'h0
`define OFS_TIMER_CTL  4'h1
`define OFS_PORT_DIR   4'h2
`define OFS_SHARED_LO  4'h3
`define OFS_SHARED_HI  4'h4
`define OFS_CAP2_LO    4'h5
`define OFS_CAP2_HI    4'h6
`define OFS_T1         4'h7
`define OFS_T2         4'h8
`define OFS_T3_LO      4'h9
`define OFS_T3_HI      4'ha
`define OFS_IRQ_STATUS 4'hb
`define OFS_IRQ_CLEAR  4'hc
`define OFS_IRQ_ENABLE 4'hd

// ****************************************
// field positions
// ****************************************
`define BIT_CAP2_OVF   7
`define BIT_CAP1_OVF   6
`define BIT_PULSE2_EN  5
`define BIT_PULSE1_EN  4
`define BIT_CAP_SEL    3
`define BIT_T3_RUN     2
`define BIT_T2_RUN     1
`define BIT_T1_RUN     0
`define BIT_WIDE       3
`define BIT_DIR_PULSE2 3
`define BIT_DIR_PULSE1 2
`define IRQ_CAP1       0
`define IRQ_CAP2       1
`define IRQ_OVF1       2
`define IRQ_OVF2       3

// ****************************************
// reset values and masks
// ****************************************
`define CONTROL_RST    8'h00
`define CONTROL_WMASK  8'h3f
`define TIMER_CTL_RST  8'h00
`define TIMER_CTL_MASK 8'h08
`define PORT_DIR_RST   8'hff
`define IRQ_RST        4'h0

`endif

//--- inc/timer_ctl_pkg.sv
// types shared by the timer control block and its capture slots
// assumes the offsets and fields of timer_ctl_regs.svh
package timer_ctl_pkg;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } reg_req_t;

  typedef struct packed {
    logic out;
    logic oe;
  } pin_drive_t;

  typedef struct packed {
    logic [15:0] value;
    logic        full;
    logic        ovf;
    logic        lo_read;
    logic        hi_read;
    logic        loaded;
    logic        overran;
  } capture_state_t;

  typedef struct packed {
    logic [7:0]  control;
    logic [7:0]  timer_ctl;
    logic [7:0]  port_dir;
    logic [7:0]  period_lo;
    logic [7:0]  period_hi;
    logic [7:0]  t1;
    logic [7:0]  t2;
    logic [15:0] t3;
    logic [3:0]  irq_status;
    logic [3:0]  irq_enable;
    logic [7:0]  rdata;
    pin_drive_t  pin1;
    pin_drive_t  pin2;
  } block_state_t;

endpackage : timer_ctl_pkg

//--- rtl/capture_slot.sv
// one capture register with unread tracking and overflow freeze
// assumes a one-cycle capture strobe and one-cycle byte read strobes
`timescale 1ns/1ns
`default_nettype none
module capture_slot
  import timer_ctl_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        arst_n,
  input  wire logic        active,
  input  wire logic        event_in,
  input  wire logic [15:0] count,
  input  wire logic        read_lo,
  input  wire logic        read_hi,
  output logic      [15:0] value,
  output logic             overflow,
  output logic             loaded,
  output logic             overran
);

  capture_state_t s;
  capture_state_t next_s;

  always_comb
  begin
    next_s         = s;
    next_s.loaded  = 1'b0;
    next_s.overran = 1'b0;
    if (read_lo)
    begin
      next_s.lo_read = 1'b1;
    end
    if (read_hi)
    begin
      next_s.hi_read = 1'b1;
    end
    if (s.full && next_s.lo_read && next_s.hi_read)
    begin
      next_s.full = 1'b0;
      next_s.ovf  = 1'b0;
    end
    // event after a completing read still loads: set beats clear
    if (active && event_in)
    begin
      if (next_s.full)
      begin
        next_s.ovf     = 1'b1;
        next_s.overran = 1'b1;
      end
      else
      begin
        next_s.value   = count;
        next_s.full    = 1'b1;
        next_s.lo_read = 1'b0;
        next_s.hi_read = 1'b0;
        next_s.loaded  = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s <= '0;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign value    = s.value;
  assign overflow = s.ovf;
  assign loaded   = s.loaded;
  assign overran  = s.overran;

endmodule : capture_slot
`default_nettype wire

//--- rtl/timer_capture_pwm_control.sv
// control and status of three timers, two captures and two pulse outputs
// assumes one clock, capture strobes and pulse levels from outside logic
`timescale 1ns/1ns
`default_nettype none
`include "timer_ctl_regs.svh"
module timer_capture_pwm_control
(
  input  wire logic                    clk_sys,
  input  wire logic                    arst_n,
  input  wire timer_ctl_pkg::reg_req_t reg_req,
  output logic                   [7:0] reg_rdata,
  input  wire logic                    capture_strobe_first,
  input  wire logic                    capture_strobe_second,
  input  wire logic                    pulse_level_first,
  input  wire logic                    pulse_level_second,
  input  wire logic                    port_latch_first,
  input  wire logic                    port_latch_second,
  output timer_ctl_pkg::pin_drive_t    first_pulse_pin,
  output timer_ctl_pkg::pin_drive_t    second_pulse_pin,
  output logic                   [7:0] first_timer_count,
  output logic                   [7:0] second_timer_count,
  output logic                  [15:0] third_timer_count,
  output logic                         irq
);
  import timer_ctl_pkg::*;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic is_write(input reg_req_t r, input logic [3:0] ofs);
    is_write = r.wr && (r.addr == ofs);
  endfunction : is_write

  function automatic logic is_read(input reg_req_t r, input logic [3:0] ofs);
    is_read = r.rd && (r.addr == ofs);
  endfunction : is_read

  // one step of an 8-bit count, wrapping at the top
  function automatic logic [7:0] bump8(input logic [7:0] v);
    bump8 = v + 8'h01;
  endfunction : bump8

  // pulse enable owns the pin, otherwise the direction bit decides
  function automatic pin_drive_t pin_drive(input logic pulse_en, input logic dir_bit,
                                           input logic level, input logic latch);
    pin_drive_t d;
    d.oe      = pulse_en | ~dir_bit;
    d.out     = pulse_en ? level : latch;
    pin_drive = d;
  endfunction : pin_drive

  // ****************************************
  // state
  // ****************************************
  block_state_t s;
  block_state_t next_s;

  logic        capture_sel;
  logic        second_capture_overrun_flag;
  logic        first_capture_overrun_flag;
  logic [15:0] cap1_value;
  logic [15:0] cap2_value;
  logic        cap1_loaded;
  logic        cap2_loaded;
  logic        cap1_overran;
  logic        cap2_overran;
  logic        cap1_read_lo;
  logic        cap1_read_hi;
  logic        cap2_read_lo;
  logic        cap2_read_hi;

  assign capture_sel = s.control[`BIT_CAP_SEL];

  // shared pair reads count as capture reads only in capture mode
  assign cap1_read_lo = is_read(reg_req, `OFS_SHARED_LO) && capture_sel;
  assign cap1_read_hi = is_read(reg_req, `OFS_SHARED_HI) && capture_sel;
  assign cap2_read_lo = is_read(reg_req, `OFS_CAP2_LO);
  assign cap2_read_hi = is_read(reg_req, `OFS_CAP2_HI);

  // ****************************************
  // capture channels
  // ****************************************
  capture_slot u_capture_first
  (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .active   (capture_sel),
    .event_in (capture_strobe_first),
    .count    (s.t3),
    .read_lo  (cap1_read_lo),
    .read_hi  (cap1_read_hi),
    .value    (cap1_value),
    .overflow (first_capture_overrun_flag),
    .loaded   (cap1_loaded),
    .overran  (cap1_overran)
  );

  capture_slot u_capture_second
  (
    .clk_sys  (clk_sys),
    .arst_n   (arst_n),
    .active   (1'b1),
    .event_in (capture_strobe_second),
    .count    (s.t3),
    .read_lo  (cap2_read_lo),
    .read_hi  (cap2_read_hi),
    .value    (cap2_value),
    .overflow (second_capture_overrun_flag),
    .loaded   (cap2_loaded),
    .overran  (cap2_overran)
  );

  // ****************************************
  // next state
  // ****************************************
  always_comb
  begin
    logic       first_timer_run;
    logic       second_timer_run;
    logic       third_timer_run;
    logic       wide_counter_mode;
    logic       first_pulse_out_enable;
    logic       second_pulse_out_enable;
    logic [3:0] irq_events;
    logic [3:0] irq_clear;
    logic [7:0] rd_value;
    first_timer_run         = s.control[`BIT_T1_RUN];
    second_timer_run        = s.control[`BIT_T2_RUN];
    third_timer_run         = s.control[`BIT_T3_RUN];
    wide_counter_mode       = s.timer_ctl[`BIT_WIDE];
    first_pulse_out_enable  = s.control[`BIT_PULSE1_EN];
    second_pulse_out_enable = s.control[`BIT_PULSE2_EN];
    irq_events              = 4'h0;
    irq_clear               = 4'h0;
    rd_value                = 8'h00;
    next_s                  = s;

    // ****************************************
    // timers
    // ****************************************
    // first timer alone, or low byte of wide counter
    if (first_timer_run)
    begin
      next_s.t1 = bump8(s.t1);
    end

    // wide mode chains the second timer to the first
    if (wide_counter_mode)
    begin
      // high byte needs both run bits
      if (first_timer_run && second_timer_run && (s.t1 == 8'hff))
      begin
        next_s.t2 = bump8(s.t2);
      end
    end
    // second timer gated by its run bit
    else if (second_timer_run)
    begin
      next_s.t2 = bump8(s.t2);
    end

    if (third_timer_run)
    begin
      // period wrap only in period mode
      if (!capture_sel && (s.t3 == {s.period_hi, s.period_lo}))
      begin
        next_s.t3 = 16'h0000;
      end
      else
      begin
        next_s.t3 = s.t3 + 16'h0001;
      end
    end

    // ****************************************
    // software writes
    // ****************************************
    if (is_write(reg_req, `OFS_CONTROL))
    begin
      next_s.control = reg_req.wdata & `CONTROL_WMASK;
    end
    if (is_write(reg_req, `OFS_TIMER_CTL))
    begin
      next_s.timer_ctl = reg_req.wdata & `TIMER_CTL_MASK;
    end
    if (is_write(reg_req, `OFS_PORT_DIR))
    begin
      next_s.port_dir = reg_req.wdata;
    end
    // period writable only in period mode
    if (is_write(reg_req, `OFS_SHARED_LO) && !capture_sel)
    begin
      next_s.period_lo = reg_req.wdata;
    end
    if (is_write(reg_req, `OFS_SHARED_HI) && !capture_sel)
    begin
      next_s.period_hi = reg_req.wdata;
    end
    if (is_write(reg_req, `OFS_T1))
    begin
      next_s.t1 = reg_req.wdata;
    end
    if (is_write(reg_req, `OFS_T2))
    begin
      next_s.t2 = reg_req.wdata;
    end
    if (is_write(reg_req, `OFS_T3_LO))
    begin
      next_s.t3[7:0] = reg_req.wdata;
    end
    if (is_write(reg_req, `OFS_T3_HI))
    begin
      next_s.t3[15:8] = reg_req.wdata;
    end
    if (is_write(reg_req, `OFS_IRQ_ENABLE))
    begin
      next_s.irq_enable = reg_req.wdata[3:0];
    end
    if (is_write(reg_req, `OFS_IRQ_CLEAR))
    begin
      irq_clear = reg_req.wdata[3:0];
    end

    // ****************************************
    // sticky status, a new event beats a clear
    // ****************************************
    irq_events[`IRQ_CAP1] = cap1_loaded;
    irq_events[`IRQ_CAP2] = cap2_loaded;
    irq_events[`IRQ_OVF1] = cap1_overran;
    irq_events[`IRQ_OVF2] = cap2_overran;
    next_s.irq_status     = (s.irq_status & ~irq_clear) | irq_events;

    // ****************************************
    // read mux, answer in the next cycle only
    // ****************************************
    unique case (reg_req.addr)
      `OFS_CONTROL:
      begin
        // flags shown at bits 7 and 6
        rd_value                = s.control & `CONTROL_WMASK;
        rd_value[`BIT_CAP2_OVF] = second_capture_overrun_flag;
        rd_value[`BIT_CAP1_OVF] = first_capture_overrun_flag;
      end
      `OFS_TIMER_CTL:  rd_value = s.timer_ctl;
      `OFS_PORT_DIR:   rd_value = s.port_dir;
      `OFS_SHARED_LO:  rd_value = capture_sel ? cap1_value[7:0] : s.period_lo;
      `OFS_SHARED_HI:  rd_value = capture_sel ? cap1_value[15:8] : s.period_hi;
      `OFS_CAP2_LO:    rd_value = cap2_value[7:0];
      `OFS_CAP2_HI:    rd_value = cap2_value[15:8];
      `OFS_T1:         rd_value = s.t1;
      `OFS_T2:         rd_value = s.t2;
      `OFS_T3_LO:      rd_value = s.t3[7:0];
      `OFS_T3_HI:      rd_value = s.t3[15:8];
      `OFS_IRQ_STATUS: rd_value = {4'h0, s.irq_status};
      `OFS_IRQ_ENABLE: rd_value = {4'h0, s.irq_enable};
      default:         rd_value = 8'h00;
    endcase
    next_s.rdata = reg_req.rd ? rd_value : 8'h00;

    // ****************************************
    // pin drive
    // ****************************************
    // pulse enable overrides port direction
    next_s.pin1 = pin_drive(first_pulse_out_enable, s.port_dir[`BIT_DIR_PULSE1],
                            pulse_level_first, port_latch_first);
    next_s.pin2 = pin_drive(second_pulse_out_enable, s.port_dir[`BIT_DIR_PULSE2],
                            pulse_level_second, port_latch_second);
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s            <= '0;
      s.control    <= `CONTROL_RST;
      s.timer_ctl  <= `TIMER_CTL_RST;
      s.port_dir   <= `PORT_DIR_RST;
      s.irq_status <= `IRQ_RST;
      s.irq_enable <= `IRQ_RST;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign reg_rdata          = s.rdata;
  assign first_pulse_pin    = s.pin1;
  assign second_pulse_pin   = s.pin2;
  assign first_timer_count  = s.t1;
  assign second_timer_count = s.t2;
  assign third_timer_count  = s.t3;
  assign irq                = |(s.irq_status & s.irq_enable);

endmodule : timer_capture_pwm_control
`default_nettype wire

//--- testbench/timer_ctl_assertions.sv
// port-level checks for the timer control block
// assumes control, port direction and wide mode are mirrored from register writes
`timescale 1ns/1ns
`default_nettype none
`include "timer_ctl_regs.svh"
module timer_ctl_assertions
(
  input wire logic                     clk_sys,
  input wire logic                     arst_n,
  input wire timer_ctl_pkg::reg_req_t  reg_req,
  input wire logic               [7:0] reg_rdata,
  input wire logic                     capture_strobe_second,
  input wire timer_ctl_pkg::pin_drive_t first_pulse_pin,
  input wire timer_ctl_pkg::pin_drive_t second_pulse_pin,
  input wire logic               [7:0] first_timer_count,
  input wire logic               [7:0] second_timer_count,
  input wire logic              [15:0] third_timer_count,
  input wire logic                     irq
);
  import timer_ctl_pkg::*;
  // ****************************************
  // register mirrors
  // ****************************************
  logic [7:0] ctl;
  logic [7:0] dir;
  logic       wide;
  wire logic  wr_t1 = reg_req.wr && reg_req.addr == `OFS_T1;
  wire logic  wr_t2 = reg_req.wr && reg_req.addr == `OFS_T2;
  wire logic  wr_t3 = reg_req.wr && (reg_req.addr == `OFS_T3_LO || reg_req.addr == `OFS_T3_HI);
  always_ff @(posedge clk_sys or negedge arst_n)
    if (!arst_n)
    begin
      ctl  <= 8'h00;
      dir  <= 8'hff;
      wide <= 1'b0;
    end
    else if (reg_req.wr)
    begin
      if (reg_req.addr == `OFS_CONTROL) ctl <= reg_req.wdata & `CONTROL_WMASK;
      if (reg_req.addr == `OFS_PORT_DIR) dir <= reg_req.wdata;
      if (reg_req.addr == `OFS_TIMER_CTL) wide <= reg_req.wdata[3];
    end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!arst_n);
  // ****************************************
  // properties
  // ****************************************
  property p_rd_idle;
    !$past(reg_req.rd) |-> reg_rdata == 8'h00;
  endproperty
  property p_rd_ctl;
    reg_req.rd && reg_req.addr == `OFS_CONTROL |=> reg_rdata[5:0] == $past(ctl[5:0]);
  endproperty
  property p_t1_inc;
    $past(ctl[0] && !wr_t1) |-> first_timer_count == $past(first_timer_count) + 8'h01;
  endproperty
  property p_t1_hold;
    $past(!ctl[0] && !wr_t1) |-> $stable(first_timer_count);
  endproperty
  property p_t2_gate;
    $past(!ctl[1] && !wr_t2) |-> $stable(second_timer_count);
  endproperty
  property p_wide;
    $past(wide && ctl[1:0] == 2'b11 && first_timer_count == 8'hff && !wr_t2)
      |-> second_timer_count == $past(second_timer_count) + 8'h01;
  endproperty
  property p_t3_stop;
    $past(!ctl[2] && !wr_t3) |-> $stable(third_timer_count);
  endproperty
  property p_pin1;
    $stable(ctl) && $stable(dir) |-> first_pulse_pin.oe == (ctl[4] | ~dir[2]);
  endproperty
  property p_pin2;
    $stable(ctl) && $stable(dir) |-> second_pulse_pin.oe == (ctl[5] | ~dir[3]);
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
  a_rd_ctl: assert property (p_rd_ctl) else $error("control read back wrong");
  a_t1_inc: assert property (p_t1_inc) else $error("first timer did not count");
  a_t1_hold: assert property (p_t1_hold) else $error("first timer moved while off");
  a_t2_gate: assert property (p_t2_gate) else $error("second timer moved while off");
  a_wide: assert property (p_wide) else $error("wide carry missing");
  a_t3_stop: assert property (p_t3_stop) else $error("third timer moved while off");
  a_pin1: assert property (p_pin1) else $error("first pin enable wrong");
  a_pin2: assert property (p_pin2) else $error("second pin enable wrong");
  c_cap2: cover property (capture_strobe_second);
  c_irq: cover property ($rose(irq));
  c_carry: cover property (wide && ctl[1:0] == 2'b11 && first_timer_count == 8'hff);
endmodule : timer_ctl_assertions
`default_nettype wire

//--- testbench/tb_timer_capture_pwm_control.sv
// self-checking bench for the timer control block
// assumes the offsets of timer_ctl_regs.svh and a 100 MHz clock
`timescale 1ns/1ns
`default_nettype none
`include "timer_ctl_regs.svh"
module tb_timer_capture_pwm_control;
  import timer_ctl_pkg::*;
  logic        clk_sys = 1'b0;
  logic        arst_n  = 1'b0;
  reg_req_t    req     = '0;
  logic [7:0]  rdata;
  logic        cap1    = 1'b0;
  logic        cap2    = 1'b0;
  logic        lvl1    = 1'b1;
  logic        lvl2    = 1'b0;
  logic        lat1    = 1'b0;
  logic        lat2    = 1'b1;
  pin_drive_t  pin1;
  pin_drive_t  pin2;
  logic [7:0]  t1;
  logic [7:0]  t2;
  logic [15:0] t3;
  logic        irq;
  int          err_count = 0;
  int          comparisons = 0;
  always #5 clk_sys = ~clk_sys;
  timer_capture_pwm_control DUT (
    .clk_sys(clk_sys), .arst_n(arst_n), .reg_req(req), .reg_rdata(rdata),
    .capture_strobe_first(cap1), .capture_strobe_second(cap2),
    .pulse_level_first(lvl1), .pulse_level_second(lvl2),
    .port_latch_first(lat1), .port_latch_second(lat2),
    .first_pulse_pin(pin1), .second_pulse_pin(pin2), .first_timer_count(t1),
    .second_timer_count(t2), .third_timer_count(t3), .irq(irq));
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    chk(16'(rdata), 16'(e));
  endtask : rd
  task automatic pulse(input logic second);
    @(posedge clk_sys);
    if (second) cap2 <= 1'b1;
    else cap1 <= 1'b1;
    @(posedge clk_sys);
    cap1 <= 1'b0;
    cap2 <= 1'b0;
  endtask : pulse
  task automatic settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle
  task automatic tally_and_finish;
    if (err_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : tally_and_finish
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    err_count++;
    tally_and_finish();
  end
  // ****************************************
  // test sequence
  // ****************************************
  initial
  begin
    repeat (6) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(`OFS_CONTROL, 8'h00);
    rd(`OFS_PORT_DIR, 8'hff);
    rd(4'he, 8'h00);
    chk(16'({pin1.oe, pin2.oe}), 16'h0);
    // pin direction takeover
    wr(`OFS_PORT_DIR, 8'hf3);
    settle();
    chk(16'({pin1, pin2}), 16'h7);
    wr(`OFS_PORT_DIR, 8'hff);
    wr(`OFS_CONTROL, 8'h10);
    settle();
    chk(16'({pin1, pin2}), 16'he);
    wr(`OFS_CONTROL, 8'h20);
    settle();
    chk(16'({pin1, pin2}), 16'h1);
    wr(`OFS_CONTROL, 8'h00);
    settle();
    chk(16'({pin1, pin2}), 16'h2);
    // wide carry then 8-bit gating
    wr(`OFS_TIMER_CTL, 8'h08);
    rd(`OFS_TIMER_CTL, 8'h08);
    wr(`OFS_T1, 8'hff);
    wr(`OFS_T2, 8'h05);
    wr(`OFS_CONTROL, 8'h03);
    wr(`OFS_CONTROL, 8'h00);
    rd(`OFS_T1, 8'h01);
    rd(`OFS_T2, 8'h06);
    wr(`OFS_TIMER_CTL, 8'h00);
    wr(`OFS_CONTROL, 8'h01);
    wr(`OFS_CONTROL, 8'h02);
    wr(`OFS_CONTROL, 8'h00);
    settle();
    chk(16'(t1), 16'h03);
    chk(16'(t2), 16'h08);
    // third timer with period two
    wr(`OFS_SHARED_LO, 8'h02);
    wr(`OFS_SHARED_HI, 8'h00);
    wr(`OFS_CONTROL, 8'h04);
    wr(`OFS_CONTROL, 8'h00);
    rd(`OFS_T3_LO, 8'h02);
    wr(`OFS_CONTROL, 8'h04);
    wr(`OFS_CONTROL, 8'h00);
    rd(`OFS_T3_LO, 8'h01);
    chk(16'(t3), 16'h0001);
    // second capture overflow and freeze
    wr(`OFS_T3_LO, 8'h78);
    wr(`OFS_T3_HI, 8'h56);
    wr(`OFS_IRQ_ENABLE, 8'h0f);
    pulse(1'b1);
    wr(`OFS_T3_LO, 8'h99);
    pulse(1'b1);
    rd(`OFS_CONTROL, 8'h80);
    chk(16'(irq), 16'h1);
    rd(`OFS_IRQ_STATUS, 8'h0a);
    rd(`OFS_CAP2_HI, 8'h56);
    rd(`OFS_CAP2_LO, 8'h78);
    rd(`OFS_CONTROL, 8'h00);
    pulse(1'b1);
    rd(`OFS_CAP2_LO, 8'h99);
    wr(`OFS_IRQ_ENABLE, 8'h00);
    settle();
    chk(16'(irq), 16'h0);
    wr(`OFS_IRQ_ENABLE, 8'h0f);
    wr(`OFS_IRQ_CLEAR, 8'h0f);
    settle();
    chk(16'(irq), 16'h0);
    // first capture in capture mode
    wr(`OFS_CONTROL, 8'h08);
    wr(`OFS_T3_LO, 8'h11);
    pulse(1'b0);
    rd(`OFS_SHARED_LO, 8'h11);
    rd(`OFS_SHARED_HI, 8'h56);
    rd(`OFS_IRQ_STATUS, 8'h01);
    // first capture overflow at bit 6
    wr(`OFS_T3_LO, 8'h22);
    pulse(1'b0);
    pulse(1'b0);
    rd(`OFS_CONTROL, 8'h48);
    rd(`OFS_IRQ_STATUS, 8'h05);
    rd(`OFS_SHARED_LO, 8'h22);
    rd(`OFS_SHARED_HI, 8'h56);
    rd(`OFS_CONTROL, 8'h08);
    // third timer passes the old period in capture mode
    wr(`OFS_T3_LO, 8'h02);
    wr(`OFS_T3_HI, 8'h00);
    wr(`OFS_CONTROL, 8'h0c);
    wr(`OFS_CONTROL, 8'h08);
    settle();
    chk(16'(t3), 16'h0004);
    // reset in capture mode with timers stopped clears control, period and third count
    @(posedge clk_sys);
    arst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    arst_n <= 1'b1;
    rd(`OFS_CONTROL, 8'h00);
    rd(`OFS_SHARED_LO, 8'h00);
    chk(16'(t3), 16'h0000);
    chk(16'(irq), 16'h0);
    chk(16'({pin1.oe, pin2.oe}), 16'h0);
    tally_and_finish();
  end
endmodule : tb_timer_capture_pwm_control
bind timer_capture_pwm_control timer_ctl_assertions u_chk (
  .clk_sys, .arst_n, .reg_req, .reg_rdata, .capture_strobe_second, .first_pulse_pin,
  .second_pulse_pin, .first_timer_count, .second_timer_count, .third_timer_count, .irq);
`default_nettype wire
